// *** rtl/sae_pkg.sv ***
// Package for the serial audio error control block
package sae_pkg;
  localparam logic [7:0]  ADDR_CTRL2    = 8'h00;
  localparam logic [7:0]  ADDR_CTRL1    = 8'h04;
  localparam logic [7:0]  ADDR_STAT     = 8'h08;
  localparam logic [7:0]  ADDR_MASK     = 8'h0C;
  localparam logic [7:0]  ADDR_TXDATA   = 8'h10;
  localparam logic [7:0]  ADDR_RXDATA   = 8'h14;
  localparam logic [31:0] CTRL2_RST     = 32'h0000_0000;
  localparam logic [31:0] CTRL2_WMASK   = 32'h0000_9F8B;
  localparam logic [31:0] CTRL2_AUDMASK = 32'h0000_008B;
  localparam int          B_SGNEXT      = 15;
  localparam int          B_FRMEN       = 12;
  localparam int          B_ROVEN       = 11;
  localparam int          B_TUREN       = 10;
  localparam int          B_IGNORE_RX_OVERFLOW      = 9;
  localparam int          B_IGNORE_TX_UNDERRUN      = 8;
  localparam int          B_AUDIO_PROTOCOL_EN       = 7;
  localparam int          B_MONO        = 3;
  localparam int          B_FMT         = 0;
  localparam int          B_ON          = 0;
  localparam int          ST_FRM        = 0;
  localparam int          ST_ROV        = 1;
  localparam int          ST_TUR        = 2;
  localparam int          ST_W          = 3;
  localparam logic [1:0]  FMT_I2S       = 2'h0;
  localparam logic [1:0]  FMT_LJ        = 2'h1;
  localparam logic [1:0]  FMT_RJ        = 2'h2;
  localparam logic [1:0]  FMT_PCM       = 2'h3;
  localparam logic [4:0]  BITS_LAST     = 5'h0F;
  localparam logic [31:0] ERR_NONE      = 32'h0000_0000;

  typedef struct packed {
    logic       sign_ext;
    logic       frm_en;
    logic       rov_en;
    logic       tur_en;
    logic       ign_rov;
    logic       ign_tur;
    logic       aud_en;
    logic       mono;
    logic [1:0] fmt;
  } sae_cfg_t;

  typedef enum logic [1:0] {
    SAE_IDLE = 2'b00,
    SAE_SHIFT = 2'b01,
    SAE_HALT = 2'b10
  } sae_state_t;
endpackage

// *** rtl/sae_top.sv ***
// Serial port with control register two, error events and audio framing
// Summary of operation
// - Sign extension bit set: receive words read sign extended to 32 bits.
// - Frame error event is gated by its enable bit, but its source is tied low, so it is never raised.
// - Receive overflow raises an error event only when its enable bit is set.
// - Transmit underrun raises an error event only when its enable bit is set.
// - Ignore overflow set: overflow not critical, held receive data kept.
// - Ignore overflow clear: overflow is critical and halts the port.
// - Ignore underrun set: underrun not critical, zeros shifted until data written.
// - Ignore underrun clear: underrun is critical and halts the port.
// - Audio enable selects codec framing; clear gives plain serial interface.
// - Mono sends each word in both channel slots; else words alternate stereo.
// - Format field: 00 I2S, 01 left, 10 right justified, 11 PCM/DSP.
// - Audio fields writable only while the port enable bit is zero.
// - Mono and format are honoured only when audio enable is one.
// - Upper sixteen and unimplemented bits ignore writes and read zero.
`timescale 1ns/1ps
module sae_top
  import sae_pkg::*;
#(
  parameter int WORD_W = 16
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        SCK_IN,
  input  wire logic        SDI_IN,
  output logic             SDO_OUT,
  output logic             LRCK_OUT,
  output logic             IRQ_OUT
);
  logic [31:0]      ctrl2_q, ctrl2_d;
  logic             on_q, on_d;
  logic [ST_W-1:0]  stat_q, stat_d, mask_q, mask_d;
  logic [WORD_W-1:0] txb_q, txb_d, rxb_q, rxb_d, tsh_q, tsh_d, rsh_q, rsh_d;
  logic             txf_q, txf_d, rxf_q, rxf_d, slot_q, slot_d, mono_rep_q, mono_rep_d;
  logic [WORD_W-1:0] rep_q, rep_d;
  logic [31:0]      prdata_d;
  logic             sdo_d, lrck_d, irq_d;
  logic [4:0]       cnt_q, cnt_d;
  sae_state_t       st_q, st_d;
  logic [2:0]       sck_s, sdi_s;
  logic             sck_rise, sck_fall;
  logic             wr, rd, ev_frm, ev_rov, ev_tur;
  logic [ST_W-1:0]  ev;
  logic [31:0]      rx_rd;
  sae_cfg_t         cfg;

  assign cfg = '{sign_ext: ctrl2_q[B_SGNEXT], frm_en: ctrl2_q[B_FRMEN], rov_en: ctrl2_q[B_ROVEN],
                 tur_en: ctrl2_q[B_TUREN], ign_rov: ctrl2_q[B_IGNORE_RX_OVERFLOW], ign_tur: ctrl2_q[B_IGNORE_TX_UNDERRUN],
                 aud_en: ctrl2_q[B_AUDIO_PROTOCOL_EN], mono: ctrl2_q[B_MONO], fmt: ctrl2_q[B_FMT+1:B_FMT]};

  // Two flops before any logic; third stage only for edge finding
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], SCK_IN};
      sdi_s <= {sdi_s[1:0], SDI_IN};
    end
  end
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];

  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = 1'b0;

  // Frame error: frame clock changed mid-word in audio mode (no external frame pin, so unused here)
  assign ev_frm = 1'b0;

  always_comb begin
    rx_rd = {{(32-WORD_W){1'b0}}, rxb_q};
    if (cfg.sign_ext) begin
      rx_rd = {{(32-WORD_W){rxb_q[WORD_W-1]}}, rxb_q};
    end
  end

  // Control registers; audio fields frozen while the port runs
  always_comb begin
    ctrl2_d = ctrl2_q;
    on_d = on_q;
    mask_d = mask_q;
    if (wr && PADDR_IN == ADDR_CTRL2) begin
      if (on_q) begin
        ctrl2_d = ((PWDATA_IN & CTRL2_WMASK & ~CTRL2_AUDMASK) | (ctrl2_q & CTRL2_AUDMASK));
      end else begin
        ctrl2_d = PWDATA_IN & CTRL2_WMASK;
      end
    end
    if (wr && PADDR_IN == ADDR_CTRL1) begin
      on_d = PWDATA_IN[B_ON];
    end
    if (wr && PADDR_IN == ADDR_MASK) begin
      mask_d = PWDATA_IN[ST_W-1:0];
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl2_q <= CTRL2_RST;
      on_q <= 1'b0;
      mask_q <= '0;
    end else begin
      ctrl2_q <= ctrl2_d;
      on_q <= on_d;
      mask_q <= mask_d;
    end
  end

  // Buffers and shifter
  always_comb begin
    txb_d = txb_q;
    txf_d = txf_q;
    rxb_d = rxb_q;
    rxf_d = rxf_q;
    tsh_d = tsh_q;
    rsh_d = rsh_q;
    rep_d = rep_q;
    cnt_d = cnt_q;
    slot_d = slot_q;
    mono_rep_d = mono_rep_q;
    st_d = st_q;
    ev_rov = 1'b0;
    ev_tur = 1'b0;
    if (wr && PADDR_IN == ADDR_TXDATA) begin
      txb_d = PWDATA_IN[WORD_W-1:0];
      txf_d = 1'b1;
    end
    if (rd && PADDR_IN == ADDR_RXDATA) begin
      rxf_d = 1'b0;
    end
    unique case (st_q)
      SAE_IDLE: begin
        cnt_d = 5'h0;
        slot_d = 1'b0;
        if (on_q) begin
          // First word loaded at switch-on; an empty buffer sends zeros
          tsh_d = txf_q ? txb_q : '0;
          rep_d = txf_q ? txb_q : '0;
          txf_d = (wr && PADDR_IN == ADDR_TXDATA);
          mono_rep_d = cfg.aud_en & cfg.mono;
          st_d = SAE_SHIFT;
        end
      end
      SAE_SHIFT: begin
        if (!on_q) begin
          st_d = SAE_IDLE;
        end else if (sck_rise) begin
          rsh_d = {rsh_q[WORD_W-2:0], sdi_s[1]};
        end else if (sck_fall) begin
          tsh_d = {tsh_q[WORD_W-2:0], 1'b0};
          cnt_d = cnt_q + 5'h1;
          if (cnt_q == 5'(WORD_W-1)) begin
            cnt_d = 5'h0;
            slot_d = ~slot_q; // each word takes one slot unless mono
            if (rxf_q) begin
              ev_rov = 1'b1;
              if (!cfg.ign_rov) begin
                st_d = SAE_HALT;
              end
              // Held data kept when ignoring overflow
            end else begin
              rxb_d = rsh_q;
              rxf_d = 1'b1;
            end
            // Copy of the left word kept, so a fresh write cannot replace the right slot
            if (mono_rep_q && !slot_q) begin
              tsh_d = rep_q;
              mono_rep_d = 1'b1;
            end else if (txf_q) begin
              tsh_d = txb_q;
              rep_d = txb_q;
              txf_d = (wr && PADDR_IN == ADDR_TXDATA);
            end else begin
              ev_tur = 1'b1;
              tsh_d = '0;
              rep_d = '0;
              if (!cfg.ign_tur) begin
                st_d = SAE_HALT;
              end
            end
          end
        end
      end
      SAE_HALT: begin
        if (!on_q) begin
          st_d = SAE_IDLE;
        end
      end
      default: st_d = SAE_IDLE;
    endcase
  end

  // Event enables gate sticky status; set wins over clear
  assign ev[ST_FRM] = ev_frm & cfg.frm_en;
  assign ev[ST_ROV] = ev_rov & cfg.rov_en;
  assign ev[ST_TUR] = ev_tur & cfg.tur_en;
  always_comb begin
    stat_d = stat_q;
    if (wr && PADDR_IN == ADDR_STAT) begin
      stat_d = stat_q & ~PWDATA_IN[ST_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  // Buffer and shifter state
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      txb_q <= '0;
      txf_q <= 1'b0;
      rxb_q <= '0;
      rxf_q <= 1'b0;
      tsh_q <= '0;
      rsh_q <= '0;
      rep_q <= '0;
      cnt_q <= 5'h0;
      slot_q <= 1'b0;
      mono_rep_q <= 1'b0;
      st_q <= SAE_IDLE;
    end else begin
      txb_q <= txb_d;
      txf_q <= txf_d;
      rxb_q <= rxb_d;
      rxf_q <= rxf_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      rep_q <= rep_d;
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      mono_rep_q <= mono_rep_d;
      st_q <= st_d;
    end
  end

  // Status; only a written one clears a bit, reads leave it
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Output next values; every output but the tied PREADY_OUT and PSLVERR_OUT leaves through a flop
  always_comb begin
    sdo_d = 1'b0;
    if (st_d == SAE_SHIFT) begin
      sdo_d = tsh_d[WORD_W-1];
    end
    // Frame clock only in audio mode; LJ/RJ use slot level, I2S slot level one bit early, PCM a pulse at left slot start
    if (!cfg.aud_en) begin
      lrck_d = 1'b0;
    end else if (cfg.fmt == FMT_PCM) begin
      lrck_d = (st_d == SAE_SHIFT) && (cnt_d == 5'h0) && !slot_d;
    end else if (cfg.fmt == FMT_I2S) begin
      lrck_d = slot_d ^ (cnt_d == BITS_LAST);
    end else begin
      lrck_d = slot_d;
    end
    irq_d = |(stat_d & mask_q);
    // Latched in setup so it stands through the whole access cycle
    prdata_d = 32'h0;
    if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      unique case (PADDR_IN)
        ADDR_CTRL2:  prdata_d = ctrl2_q;
        ADDR_CTRL1:  prdata_d = {31'h0, on_q};
        ADDR_STAT:   prdata_d = {29'h0, stat_q};
        ADDR_MASK:   prdata_d = {29'h0, mask_q};
        ADDR_RXDATA: prdata_d = rx_rd;
        default:     prdata_d = ERR_NONE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= 32'h0;
      SDO_OUT <= 1'b0;
      LRCK_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      PRDATA_OUT <= prdata_d;
      SDO_OUT <= sdo_d;
      LRCK_OUT <= lrck_d;
      IRQ_OUT <= irq_d;
    end
  end
endmodule

// *** verif/sae_codec.sv ***
// Codec model: bit clock master, fixed word out, captures port output
`timescale 1ns/1ps
module sae_codec #(
  parameter logic [15:0] WORD = 16'h8001
) (
  input  wire logic        run_in,
  input  wire logic        sdo_in,
  output logic             sck_out,
  output logic             sdi_out,
  output logic [15:0]      got_out
);
  int b = 15;
  initial begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    got_out = 16'h0;
    forever begin
      @(posedge run_in);
      #13;
      // Whole words only, keeps the port's bit count aligned
      do begin
        sdi_out = WORD[b];
        #200 sck_out = 1'b1;
        got_out = {got_out[14:0], sdo_in};
        #200 sck_out = 1'b0;
        b = (b + 15) % 16;
      end while (run_in || b != 15);
      sdi_out = ~sdi_out;
    end
  end
endmodule

// *** verif/sae_props.sv ***
// Checker for control two, events and interrupt
`timescale 1ns/1ps
module sae_props
  import sae_pkg::*;
#(parameter int WORD_W = 16) (
  input wire logic        MCLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        LRCK_OUT,
  input wire logic        IRQ_OUT
);
  logic [31:0] c2_q, c2_d;
  logic [2:0]  ok_q, ok_d, mk_q, mk_d;
  logic        on_q, on_d;
  wire         wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire         rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  // Shadow state; ok marks events whose enable was on since last clear
  always_comb begin
    c2_d = c2_q;
    on_d = on_q;
    mk_d = mk_q;
    ok_d = ok_q & ~((wr && PADDR_IN == ADDR_STAT) ? PWDATA_IN[2:0] : 3'h0);
    ok_d = ok_d | {c2_q[B_TUREN], c2_q[B_ROVEN], c2_q[B_FRMEN]};
    if (wr && PADDR_IN == ADDR_CTRL1) on_d = PWDATA_IN[B_ON];
    if (wr && PADDR_IN == ADDR_MASK) mk_d = PWDATA_IN[2:0];
    if (wr && PADDR_IN == ADDR_CTRL2) c2_d = on_q ? (c2_q & CTRL2_AUDMASK) | (PWDATA_IN & CTRL2_WMASK & ~CTRL2_AUDMASK)
                                                  : PWDATA_IN & CTRL2_WMASK;
  end
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {c2_q, on_q, mk_q, ok_q} <= '0;
    end else begin
      {c2_q, on_q, mk_q, ok_q} <= {c2_d, on_d, mk_d, ok_d};
    end
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  sequence s_rd(logic [7:0] a); rd && PADDR_IN == a; endsequence
  property p_c2_rd; s_rd(ADDR_CTRL2) |-> PRDATA_OUT == c2_q; endproperty
  a_c2_rd: assert property (p_c2_rd) else $error("ctrl2 readback");
  property p_c2_rsv; s_rd(ADDR_CTRL2) |-> (PRDATA_OUT & ~CTRL2_WMASK) == 32'h0; endproperty
  a_c2_rsv: assert property (p_c2_rsv) else $error("ctrl2 reserved bits");
  property p_sx; s_rd(ADDR_RXDATA) ##0 c2_q[B_SGNEXT] |-> PRDATA_OUT[31:WORD_W] == {(32-WORD_W){PRDATA_OUT[WORD_W-1]}}; endproperty
  a_sx: assert property (p_sx) else $error("rx not extended");
  property p_nosx; s_rd(ADDR_RXDATA) ##0 !c2_q[B_SGNEXT] |-> PRDATA_OUT[31:WORD_W] == '0; endproperty
  a_nosx: assert property (p_nosx) else $error("rx extended");
  property p_lr; !c2_q[B_AUDIO_PROTOCOL_EN] && !$past(c2_q[B_AUDIO_PROTOCOL_EN]) && !$past(c2_q[B_AUDIO_PROTOCOL_EN], 2) |-> !LRCK_OUT; endproperty
  a_lr: assert property (p_lr) else $error("frame clock without audio");
  property p_evt; s_rd(ADDR_STAT) |-> (PRDATA_OUT[2:0] & ~ok_q) == 3'h0; endproperty
  a_evt: assert property (p_evt) else $error("event while disabled");
  property p_irq0; mk_q == 3'h0 && $past(mk_q) == 3'h0 && $past(mk_q, 2) == 3'h0 |-> !IRQ_OUT; endproperty
  a_irq0: assert property (p_irq0) else $error("irq while masked");
  property p_irq1; s_rd(ADDR_STAT) ##0 (PRDATA_OUT[2:0] & mk_q) != 3'h0 ##0 $stable(mk_q) |-> ##[0:2] IRQ_OUT; endproperty
  a_irq1: assert property (p_irq1) else $error("irq missing");
endmodule

// *** verif/sae_top_tb.sv ***
// Testbench for the serial audio error control block
`timescale 1ns/1ps
module sae_top_tb;
  import sae_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0, lr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, sck, sdi, sdo, lrck, irq;
  logic [15:0] got;
  int          n_errors = 0, n_compared = 0, cyc = 0;
  sae_top #(.WORD_W(16)) dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(), .SCK_IN(sck), .SDI_IN(sdi), .SDO_OUT(sdo), .LRCK_OUT(lrck), .IRQ_OUT(irq));
  sae_codec #(.WORD(16'h8001)) u_codec (.run_in(run), .sdo_in(sdo), .sck_out(sck), .sdi_out(sdi), .got_out(got));
  initial forever #25 clk = ~clk;
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (lrck === 1'b1 && run === 1'b1) lr <= 1'b1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  // Link runs whole words for about n cycles with the port on; port left on for inspection
  task automatic link(input logic [31:0] c2, input int n);
    apb(1'b1, ADDR_CTRL2, c2);
    apb(1'b1, ADDR_CTRL1, 32'h1);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (200) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(ADDR_CTRL2, CTRL2_RST);
    apb(1'b1, ADDR_CTRL2, 32'hFFFF_FFFF);
    rdc(ADDR_CTRL2, CTRL2_WMASK);
    apb(1'b1, ADDR_CTRL1, 32'h1);
    apb(1'b1, ADDR_CTRL2, 32'h0);
    rdc(ADDR_CTRL2, CTRL2_AUDMASK);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, ADDR_CTRL2, 32'h80 | 32'(f));
      rdc(ADDR_CTRL2, 32'h80 | 32'(f));
    end
    apb(1'b1, ADDR_MASK, 32'h7);
    link(32'h0000_0780, 400);
    chk({16'h0, got}, ERR_NONE);
    chk({31'h0, lr}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h0);
    rdc(ADDR_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_STAT, 32'h7);
    rdc(ADDR_STAT, ERR_NONE);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h7);
    link(32'h0000_8B00, 400);
    rdc(ADDR_STAT, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rdc(ADDR_RXDATA, 32'hFFFF_8001);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_STAT, 32'h7);
    link(32'h0000_0E00, 400);
    rdc(ADDR_STAT, 32'h4);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_TXDATA, 32'h0000_A5C3);
    link(32'h0000_0388, 130);
    chk({16'h0, got}, 32'h0000_A5C3);
    end_sim();
  end
endmodule
bind sae_top sae_props #(.WORD_W(WORD_W)) u_props (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .LRCK_OUT(LRCK_OUT), .IRQ_OUT(IRQ_OUT));
